// >>> logic/cmc_top.sv
// comparator control, offset calibration and change flag with wishbone registers
// ==================================================
// Functional notes
// - invert bit flips decision into result bit
// - result bit read-only, high when plus exceeds
// - two-bit field picks four response speeds
// - unused bits ignore writes, read zero
// - mode bit selects normal or calibration
// - reference select acts only in calibration
// - five-bit trim, reset value binary 10000
// - result change sets flag, gated request
// - flag follows internal result, not pin
// - change in sleep or idle wakes
// - flag already set gives no wake
// - comparator keeps running in sleep, idle
// - comparator off forces result low
// - hysteresis on in normal with comparator on, off calibrating or off
`include "cmc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cmc_top (
  // clock and reset
  input  wire logic                 I_CORE_CLK,
  input  wire logic                 I_RST,
  // wishbone slave
  input  wire logic                 I_WB_CYC,
  input  wire logic                 I_WB_STB,
  input  wire logic                 I_WB_WE,
  input  wire logic [7:0]           I_WB_ADR,
  input  wire logic [3:0]           I_WB_SEL,
  input  wire logic [31:0]          I_WB_DAT,
  output logic      [31:0]          O_WB_DAT,
  output logic                      O_WB_ACK,
  // analog comparator side
  input  wire logic                 I_CMP_RAW,
  output logic                      O_CMP_ON,
  output var cmc_pkg::cmc_resp_t    O_RESP_SEL,
  output logic                      O_CAL_MODE,
  output logic                      O_CAL_REF_POS,
  output logic                      O_SW_A,
  output logic                      O_SW_B,
  output logic                      O_HYST_EN,
  output logic      [4:0]           O_TRIM,
  output logic                      O_RESULT,
  // system and interrupt controller side
  input  wire logic                 I_SLEEP_IDLE,
  input  wire logic                 I_MF_INT_EN,
  output logic                      O_INT_FLAG,
  output logic                      O_INT_REQ,
  output logic                      O_WAKE
);
  import cmc_pkg::*;

  // ==================================================
  // helpers
  // only the word address decodes, so byte offsets inside a word alias
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction

  // ==================================================
  // declarations
  cmc_bus_st_t bus_st_r;
  cmc_bus_st_t bus_st_nxt;
  logic        req_w;
  logic        wr_w;
  logic        on_r;
  logic        inv_r;
  cmc_resp_t   rt_r;
  logic        cal_r;
  logic        ref_r;
  logic [4:0]  trim_r;
  logic        ie_r;
  logic        flag_r;
  logic        flag_nxt;
  logic        result_r;
  logic        result_nxt;
  logic        prev_r;
  logic        change_w;
  logic [7:0]  ctrl_rd;
  logic [7:0]  trim_rd;
  logic [7:0]  stat_rd;
  logic [31:0] rdat_nxt;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        wake_r;
  logic        req_r;

  cmc_sync_if sif ();

  assign sif.raw = I_CMP_RAW;

  cmc_sync u_sync (
    .i_clk (I_CORE_CLK),
    .i_rst (I_RST),
    .sif   (sif)
  );

  // ==================================================
  // bus sequencing: one cycle to answer, ack for one cycle
  // a write lands at the take edge, the same edge that raises ack
  assign req_w = I_WB_CYC & I_WB_STB & (bus_st_r == CMC_BUS_IDLE);
  assign wr_w  = req_w & I_WB_WE & I_WB_SEL[0];

  always_comb begin
    case (bus_st_r)
      CMC_BUS_IDLE: begin
        bus_st_nxt = req_w ? CMC_BUS_ACK : CMC_BUS_IDLE;
      end
      CMC_BUS_ACK: begin
        bus_st_nxt = CMC_BUS_IDLE;
      end
      default: begin
        bus_st_nxt = CMC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      bus_st_r <= CMC_BUS_IDLE;
      ack_r    <= 1'b0;
    end else begin
      bus_st_r <= bus_st_nxt;
      ack_r    <= req_w;
    end
  end

  // ==================================================
  // control register; result bit has no write path
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      on_r  <= 1'(`CMC_RST_CTRL >> `CMC_CTRL_ON);
      inv_r <= 1'b0;
      rt_r  <= CMC_RT_SLOWEST;
    end else if (wr_w && hit(I_WB_ADR, `CMC_OFS_CTRL)) begin
      on_r  <= I_WB_DAT[`CMC_CTRL_ON];
      inv_r <= I_WB_DAT[`CMC_CTRL_INV];
      rt_r  <= cmc_resp_t'(I_WB_DAT[`CMC_CTRL_RT_HI:`CMC_CTRL_RT_LO]);
    end
  end

  // ==================================================
  // offset register
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cal_r  <= 1'b0;
      ref_r  <= 1'b0;
      trim_r <= 5'(`CMC_RST_TRIM);
    end else if (wr_w && hit(I_WB_ADR, `CMC_OFS_TRIM)) begin
      cal_r  <= I_WB_DAT[`CMC_TRIM_CAL];
      ref_r  <= I_WB_DAT[`CMC_TRIM_REF];
      trim_r <= I_WB_DAT[`CMC_TRIM_VAL_HI:`CMC_TRIM_VAL_LO];
    end
  end

  // ==================================================
  // result bit: polarity applied after synchronising, low while off
  // keeps running whatever the sleep state, so a sleeping core still sees edges
  always_comb begin
    result_nxt = on_r ? (sif.level ^ inv_r) : 1'b0;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      result_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      result_r <= result_nxt;
      prev_r   <= result_r;
    end
  end

  // edges are taken on the internal bit, never on the pin copy
  assign change_w = result_r ^ prev_r;

  // ==================================================
  // change flag: software may set or clear it, a change in the same cycle wins
  always_comb begin
    flag_nxt = flag_r;
    if (wr_w && hit(I_WB_ADR, `CMC_OFS_STAT)) begin
      flag_nxt = I_WB_DAT[`CMC_STAT_FLAG];
    end
    if (change_w) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_r <= 1'b0;
      ie_r   <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (wr_w && hit(I_WB_ADR, `CMC_OFS_STAT)) begin
        ie_r <= I_WB_DAT[`CMC_STAT_IE];
      end
    end
  end

  // ==================================================
  // wake only on a fresh flag; a flag set before sleep keeps the core asleep
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      wake_r <= 1'b0;
      req_r  <= 1'b0;
    end else begin
      wake_r <= change_w & ~flag_r & I_SLEEP_IDLE & on_r;
      req_r  <= flag_nxt & ie_r & I_MF_INT_EN;
    end
  end

  // ==================================================
  // read data; unused and reserved bits read zero, unmapped words read zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`CMC_CTRL_ON]  = on_r;
    ctrl_rd[`CMC_CTRL_INV] = inv_r;
    ctrl_rd[`CMC_CTRL_RES] = result_r;
    ctrl_rd[`CMC_CTRL_RT_HI:`CMC_CTRL_RT_LO] = rt_r;
    trim_rd = 8'h00;
    trim_rd[`CMC_TRIM_CAL] = cal_r;
    trim_rd[`CMC_TRIM_REF] = ref_r;
    trim_rd[`CMC_TRIM_VAL_HI:`CMC_TRIM_VAL_LO] = trim_r;
    stat_rd = 8'h00;
    stat_rd[`CMC_STAT_FLAG] = flag_r;
    stat_rd[`CMC_STAT_IE]   = ie_r;
    if (hit(I_WB_ADR, `CMC_OFS_CTRL)) begin
      rdat_nxt = zext8(ctrl_rd);
    end else if (hit(I_WB_ADR, `CMC_OFS_TRIM)) begin
      rdat_nxt = zext8(trim_rd);
    end else if (hit(I_WB_ADR, `CMC_OFS_STAT)) begin
      rdat_nxt = zext8(stat_rd);
    end else begin
      rdat_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdat_r <= 32'h00000000;
    end else if (req_w) begin
      // captured once per request so the word stands through ack
      rdat_r <= rdat_nxt;
    end
  end

  // ==================================================
  // analog side drives, all registered
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CMP_ON      <= 1'b0;
      O_RESP_SEL    <= CMC_RT_SLOWEST;
      O_CAL_MODE    <= 1'b0;
      O_CAL_REF_POS <= 1'b0;
      O_SW_A        <= 1'b0;
      O_SW_B        <= 1'b0;
      O_HYST_EN     <= 1'b0;
      O_TRIM        <= 5'(`CMC_RST_TRIM);
      O_RESULT      <= 1'b0;
    end else begin
      O_CMP_ON      <= on_r;
      O_RESP_SEL    <= rt_r;
      O_CAL_MODE    <= cal_r;
      O_CAL_REF_POS <= cal_r & ref_r;
      O_SW_A        <= cal_r & ref_r;
      O_SW_B        <= cal_r & ref_r;
      O_HYST_EN     <= on_r & ~cal_r;
      O_TRIM        <= trim_r;
      O_RESULT      <= result_r;
    end
  end

  assign O_WB_ACK   = ack_r;
  assign O_WB_DAT   = rdat_r;
  assign O_INT_FLAG = flag_r;
  assign O_INT_REQ  = req_r;
  assign O_WAKE     = wake_r;

  // ==================================================
  // assertions
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  res_polarity_a: assert property ($past(on_r) |-> result_r == ($past(sif.level) ^ $past(inv_r)))
    else $error("result bit does not follow decision and polarity");
  res_readonly_a: assert property (wr_w && hit(I_WB_ADR, `CMC_OFS_CTRL) && !on_r |=> !result_r)
    else $error("result bit changed by a write");
  off_low_a: assert property (!on_r [*2] |-> !result_r ##1 !O_RESULT)
    else $error("result not low while comparator off");
  rsvd_zero_a: assert property (ack_r |-> rdat_r[31:8] == 24'h000000 && !rdat_r[7])
    else $error("reserved bits read non-zero");
  ctrl_low_a: assert property (ack_r && hit($past(I_WB_ADR), `CMC_OFS_CTRL) |-> rdat_r[1:0] == 2'b00)
    else $error("unused control bits read non-zero");
  resp_pass_a: assert property (O_RESP_SEL == $past(rt_r))
    else $error("response select not driven from register");
  ref_gate_a: assert property (O_SW_A |-> O_CAL_MODE && O_CAL_REF_POS && O_SW_B)
    else $error("reference switches closed outside calibration");
  hyst_mode_a: assert property (O_HYST_EN |-> !O_CAL_MODE && O_CMP_ON)
    else $error("hysteresis on while calibrating");
  flag_set_a: assert property (change_w |=> flag_r ##1 (flag_r || $past(wr_w)))
    else $error("flag not set on result change");
  flag_sticky_a: assert property (flag_r && !wr_w |=> flag_r)
    else $error("flag dropped without software");
  wake_fresh_a: assert property (O_WAKE |-> !$past(flag_r) && $past(change_w) && $past(I_SLEEP_IDLE))
    else $error("wake without a fresh flag in sleep");
  req_gate_a: assert property (O_INT_REQ |-> $past(ie_r) && $past(I_MF_INT_EN))
    else $error("request without both enables");
  ack_pulse_a: assert property (ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");
  ack_take_a: assert property (req_w |=> ack_r)
    else $error("taken request not answered next cycle");
  // the two-stage latency is part of the documented result timing
  sync_delay_a: assert property (sif.level == $past(I_CMP_RAW, 2))
    else $error("decision not synchronised over two stages");
  wake_on_a: assert property (O_WAKE |-> $past(on_r))
    else $error("wake while comparator off");
  req_flag_a: assert property (O_INT_REQ |-> O_INT_FLAG)
    else $error("request without flag");
  trim_drive_a: assert property (O_TRIM == $past(trim_r))
    else $error("trim output not driven from register");
  flag_clear_a: assert property (wr_w && !I_WB_DAT[`CMC_STAT_FLAG] && !change_w &&
    hit(I_WB_ADR, `CMC_OFS_STAT) |=> !flag_r)
    else $error("flag not cleared by software");

  sleep_wake_c: cover property (I_SLEEP_IDLE && on_r ##1 O_WAKE);
  cal_enter_c: cover property (!O_CAL_MODE ##1 O_CAL_MODE ##[1:20] O_SW_A);
  flag_race_c: cover property (change_w && wr_w && hit(I_WB_ADR, `CMC_OFS_STAT));
  read_ctrl_c: cover property (req_w && !I_WB_WE ##1 ack_r && rdat_r[4]);
  cal_flip_c: cover property (O_CAL_MODE && change_w);

endmodule

`default_nettype wire

// >>> inc/cmc_params.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH

// ==================================================
// byte offsets on the register bus
`define CMC_OFS_CTRL     8'h00
`define CMC_OFS_TRIM     8'h04
`define CMC_OFS_STAT     8'h08

// ==================================================
// control register fields
`define CMC_CTRL_ON      6
`define CMC_CTRL_INV     5
`define CMC_CTRL_RES     4
`define CMC_CTRL_RT_HI   3
`define CMC_CTRL_RT_LO   2

// ==================================================
// offset register fields
`define CMC_TRIM_CAL     6
`define CMC_TRIM_REF     5
`define CMC_TRIM_VAL_HI  4
`define CMC_TRIM_VAL_LO  0

// ==================================================
// status register fields
`define CMC_STAT_FLAG    0
`define CMC_STAT_IE      1

// ==================================================
// reset values
`define CMC_RST_CTRL     8'h00
`define CMC_RST_TRIM     8'h10
`define CMC_RST_STAT     8'h00

`endif

// >>> inc/cmc_pkg.sv
// types shared by the comparator control block
package cmc_pkg;

  // ==================================================
  // response time codes, slowest first
  typedef enum logic [1:0] {
    CMC_RT_SLOWEST = 2'b00,
    CMC_RT_SLOW    = 2'b01,
    CMC_RT_FAST    = 2'b10,
    CMC_RT_FASTEST = 2'b11
  } cmc_resp_t;

  // ==================================================
  // register bus answer sequence
  typedef enum logic [0:0] {
    CMC_BUS_IDLE = 1'b0,
    CMC_BUS_ACK  = 1'b1
  } cmc_bus_st_t;

endpackage

// >>> inc/cmc_sync_if.sv
// carrier between the block and its decision synchroniser
`timescale 1ns/10ps
`default_nettype none

interface cmc_sync_if;
  logic raw;
  logic level;

  modport syncer (
    input  raw,
    output level
  );

  modport user (
    output raw,
    input  level
  );
endinterface

`default_nettype wire

// >>> logic/cmc_sync.sv
// two-stage synchroniser for the analog comparator decision
`timescale 1ns/10ps
`default_nettype none

module cmc_sync (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // decision in, synchronised level out
  cmc_sync_if.syncer  sif
);

  logic meta_r;
  logic sync_r;

  // ==================================================
  // the first stage feeds the second stage and nothing else
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= sif.raw;
      sync_r <= meta_r;
    end
  end

  assign sif.level = sync_r;

endmodule

`default_nettype wire

// >>> tb/cmc_analog_model.sv
// stand-in for the analog comparator and its input pins
`timescale 1ns/10ps
`default_nettype none

module cmc_analog_model #(
  parameter logic [4:0] THR = 5'h0b
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // controls from the block
  input  wire logic       i_on,
  input  wire logic       i_cal,
  input  wire logic [4:0] i_trim,
  // pin level set by the bench
  input  wire logic       i_level,
  // raw decision
  output logic            o_raw
);
  // ==================================================
  // decision: switched off reads low; calibrating, the trim decides
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_raw <= 1'b0;
    end else if (!i_on) begin
      o_raw <= 1'b0;
    end else if (i_cal) begin
      o_raw <= (i_trim > THR);
    end else begin
      o_raw <= i_level;
    end
  end
endmodule

`default_nettype wire

// >>> tb/cmc_top_test.sv
// register-level bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none

module cmc_top_test;
  import cmc_pkg::*;
  localparam logic [4:0] THR = 5'h0b;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, lvl = 0, slp = 0, mf = 0, raw;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat;
  logic ack, on, cal, refp, swa, swb, hys, res, flag, req, wake;
  logic [4:0] trim, p1, p2;
  cmc_resp_t rsel;
  int miscompares = 0, n_compared = 0, cycles = 0, wakes = 0;

  always #12.5 clk = ~clk;

  cmc_top i_cmc_top (.I_CORE_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_CMP_RAW(raw), .O_CMP_ON(on), .O_RESP_SEL(rsel), .O_CAL_MODE(cal),
    .O_CAL_REF_POS(refp), .O_SW_A(swa), .O_SW_B(swb), .O_HYST_EN(hys), .O_TRIM(trim),
    .O_RESULT(res), .I_SLEEP_IDLE(slp), .I_MF_INT_EN(mf), .O_INT_FLAG(flag),
    .O_INT_REQ(req), .O_WAKE(wake));

  cmc_analog_model #(.THR(THR)) i_cmc_analog_model (.i_clk(clk), .i_rst(rst), .i_on(on),
    .i_cal(cal), .i_trim(trim), .i_level(lvl), .o_raw(raw));

  // ==================================================
  // verdict and hang guard
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==================================================
  // wishbone classic master: hold until ack is sampled
  task wb(input logic w_e, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
          output logic [31:0] r);
    int k;
    begin
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w_e; adr <= a; dat <= {24'h0, d}; sel <= s;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (ack !== 1'b1 && k < 50);
      r = rdat;
      chk({31'h0, ack}, 32'h1);
      cyc <= 0; stb <= 0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    logic [31:0] r;
    wb(1'b1, a, d, s, r);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    begin
      wb(1'b0, a, 8'h00, 4'hf, r);
      chk(r, e);
    end
  endtask

  // trim sweep until the result bit flips; p is the trim at the flip
  task sweep(input logic [4:0] s, input logic up, output logic [4:0] p);
    logic [31:0] r;
    logic b;
    int k;
    begin
      p = s;
      wr(8'h04, {3'b011, p});
      w(6);
      wb(1'b0, 8'h00, 8'h00, 4'hf, r);
      b = r[4];
      for (k = 0; k < 31 && r[4] === b; k++) begin
        p = up ? p + 5'h01 : p - 5'h01;
        wr(8'h04, {3'b011, p});
        w(6);
        wb(1'b0, 8'h00, 8'h00, 4'hf, r);
      end
    end
  endtask

  initial begin
    w(2);
    rst <= 0;
    rdc(8'h00, 32'h00);
    rdc(8'h04, 32'h10);
    rdc(8'h08, 32'h00);
    rdc(8'h0c, 32'h00);
    chk(trim, 32'h10);
    wr(8'h04, 8'hff);
    rdc(8'h04, 32'h7f);
    chk({cal, refp, swa, swb}, 32'hf);
    wr(8'h04, 8'h20);
    w(2);
    chk({cal, refp, swa, swb}, 32'h0);
    wr(8'h00, 8'hff, 4'h0);
    rdc(8'h00, 32'h00);
    wr(8'h00, 8'hff);
    w(8);
    rdc(8'h00, 32'h7c);
    chk({on, hys, res}, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h40 | 8'(i << 2));
      w(2);
      chk({30'h0, rsel}, 32'(i));
    end
    lvl <= 1;
    w(8);
    rdc(8'h00, 32'h5c);
    wr(8'h04, 8'h10);
    wr(8'h08, 8'h02);
    mf <= 1;
    lvl <= 0;
    w(8);
    chk({flag, req}, 32'h3);
    rdc(8'h08, 32'h03);
    lvl <= 1;
    w(8);
    mf <= 0;
    w(3);
    chk({flag, req}, 32'h2);
    slp <= 1;
    wr(8'h08, 8'h00);
    wakes = 0;
    lvl <= 0;
    w(8);
    chk(wakes, 32'h1);
    lvl <= 1;
    w(8);
    chk(wakes, 32'h1);
    rdc(8'h00, 32'h5c);
    wr(8'h08, 8'h00);
    rdc(8'h08, 32'h00);
    wr(8'h08, 8'h01);
    rdc(8'h08, 32'h01);
    lvl <= 0;
    w(8);
    chk(wakes, 32'h1);
    slp <= 0;
    lvl <= 0;
    wr(8'h00, 8'h60);
    w(8);
    rdc(8'h00, 32'h70);
    wr(8'h00, 8'h30);
    w(8);
    rdc(8'h00, 32'h20);
    chk({on, res}, 32'h0);
    wr(8'h00, 8'h40);
    wr(8'h04, 8'h40);
    wr(8'h04, 8'h60);
    sweep(5'h00, 1'b1, p1);
    sweep(5'h1f, 1'b0, p2);
    wr(8'h04, {3'b011, 5'((6'(p1) + 6'(p2)) >> 1)});
    w(2);
    chk({hys, trim}, {27'h0, THR});
    report_and_stop;
  end
endmodule

`default_nettype wire
